// ---- hw/tcc_channels.sv ----
// two-channel timer capture/compare logic with APB register access
//
// How it works
// - edge/level zero releases pin to port
// - mode bit A picks preset level
// - capture edge: rising, falling or both
// - compare action: toggle, clear or set
// - overflow toggle only in compare mode
// - overflow beats simultaneous compare match
// - full-duty bit forces 100% PWM when the overflow toggle bit is also set
// - full-duty change applies next PWM cycle
// - value registers hold capture or compare
// - high read blocks capture until low read
// - high write blocks compare until low write
// - reset clears edge/level bits
// - reset clears overflow toggle bits
// - event flag on capture or match
// - buffered mode disables channel one
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module tcc_channels
(
    input  wire logic                         core_clk,
    input  wire logic                         rst_b,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [tcc_pkg::VAL_W-1:0]    counter_value,
    input  wire logic                         counter_overflow,
    input  wire logic [tcc_pkg::CH_N-1:0]     channel_pin_in,
    output logic      [tcc_pkg::CH_N-1:0]     channel_pin_out,
    output logic      [tcc_pkg::CH_N-1:0]     channel_pin_oe,
    output logic                              irq
);
    import tcc_pkg::*;

    tcc_state_type st_r;
    tcc_state_type st_nxt;

    // true when the bus address is the byte address of a register index
    function automatic logic addr_is(input logic [11:0] a, input logic [7:0] idx);
        addr_is = (a == {2'h0, idx, 2'h0});
    endfunction

    // channel function from its control byte; off also when disabled by buffering
    function automatic tcc_mode_type chan_mode(input logic [7:0] c, input logic disabled);
        if (disabled || ({c[B_ELSU], c[B_ELSL]} == ELS_OFF))
        begin
            chan_mode = TCC_PORT;
        end
        else if (c[B_BUF] || c[B_MSA])
        begin
            chan_mode = TCC_COMPARE;
        end
        else
        begin
            chan_mode = TCC_CAPTURE;
        end
    endfunction

    // apply the compare action code to the present output level
    function automatic logic cmp_action(input logic [1:0] els, input logic lvl);
        case (els)
            ELS_RISE: cmp_action = ~lvl;
            ELS_FALL: cmp_action = 1'b0;
            ELS_BOTH: cmp_action = 1'b1;
            default:  cmp_action = lvl;
        endcase
    endfunction

    // next-state logic for bus, channels and interrupt
    always_comb
    begin
        logic                       access;
        logic                       wr;
        logic                       rd;
        logic                       buf_on;
        logic                       mapped;
        logic [1:0]                 els;
        logic                       rise;
        logic                       fall;
        logic                       hit_edge;
        logic                       eq;
        logic                       inhib;
        logic                       match;
        logic                       ev;
        logic                       cmp_reg;
        logic [VAL_W-1:0]           cmp;
        logic [31:0]                rmux;
        tcc_mode_type               mode;
        access   = psel && penable;
        wr       = access && pwrite;
        rd       = access && !pwrite;
        buf_on   = st_r.ctrl[0][B_BUF];
        mapped   = addr_is(paddr, IDX_IRQ_STAT) || addr_is(paddr, IDX_IRQ_MASK);
        els      = ELS_OFF;
        rise     = 1'b0;
        fall     = 1'b0;
        hit_edge = 1'b0;
        eq       = 1'b0;
        inhib    = 1'b0;
        match    = 1'b0;
        ev       = 1'b0;
        cmp_reg  = 1'b0;
        cmp      = VAL_RST;
        rmux     = 32'h00000000;
        mode     = TCC_PORT;
        st_nxt   = st_r;

        // two-stage pin synchroniser, then the edge history stage
        st_nxt.pin_s1   = channel_pin_in;
        st_nxt.pin_s2   = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;

        // buffered pair swaps its active compare register at each overflow
        if (!buf_on)
        begin
            st_nxt.act_sel = 1'b0;
        end
        else if (counter_overflow)
        begin
            st_nxt.act_sel = ~st_r.act_sel;
        end

        for (int ch = 0; ch < CH_N; ch++)
        begin
            mode = chan_mode(st_r.ctrl[ch], (ch == 1) && buf_on);
            els  = {st_r.ctrl[ch][B_ELSU], st_r.ctrl[ch][B_ELSL]};
            // channel one registers still feed the buffered pair
            cmp_reg = (mode == TCC_COMPARE) || ((ch == 1) && buf_on);
            mapped  = mapped || addr_is(paddr, IDX_CTRL[ch]) || addr_is(paddr, IDX_VAL_HI[ch])
                      || addr_is(paddr, IDX_VAL_LO[ch]);

            // bus writes to this channel
            if (wr && addr_is(paddr, IDX_CTRL[ch]) && !((ch == 1) && buf_on))
            begin
                st_nxt.ctrl[ch][6:0] = pwdata[6:0];
                if (ch == 1)
                begin
                    st_nxt.ctrl[ch][B_BUF] = 1'b0; // only channel zero has the buffered bit
                end
                if (!pwdata[B_FLAG] && st_r.clr_armed[ch])
                begin
                    st_nxt.ctrl[ch][B_FLAG] = 1'b0;
                end
                st_nxt.clr_armed[ch] = 1'b0;
            end
            if (wr && addr_is(paddr, IDX_VAL_HI[ch]))
            begin
                st_nxt.val[ch][15:8] = pwdata[7:0];
                if (cmp_reg)
                begin
                    st_nxt.cmp_inhibit[ch] = 1'b1;
                end
            end
            if (wr && addr_is(paddr, IDX_VAL_LO[ch]))
            begin
                st_nxt.val[ch][7:0]    = pwdata[7:0];
                st_nxt.cmp_inhibit[ch] = 1'b0;
            end

            // bus reads with side effects on this channel
            if (rd && addr_is(paddr, IDX_CTRL[ch]) && st_r.ctrl[ch][B_FLAG])
            begin
                st_nxt.clr_armed[ch] = 1'b1;
            end
            if (rd && addr_is(paddr, IDX_VAL_HI[ch]) && (mode == TCC_CAPTURE))
            begin
                st_nxt.cap_block[ch] = 1'b1;
            end
            if (rd && addr_is(paddr, IDX_VAL_LO[ch]))
            begin
                st_nxt.cap_block[ch] = 1'b0;
            end

            // compare value: the buffered pair uses the active register
            if ((ch == 0) && buf_on)
            begin
                cmp   = st_r.val[st_r.act_sel];
                inhib = st_r.cmp_inhibit[st_r.act_sel];
            end
            else
            begin
                cmp   = st_r.val[ch];
                inhib = st_r.cmp_inhibit[ch];
            end
            eq                    = (counter_value == cmp);
            st_nxt.match_prev[ch] = eq;
            match                 = (mode == TCC_COMPARE) && eq && !st_r.match_prev[ch] && !inhib;

            // synchronised edges
            rise     = st_r.pin_s2[ch] && !st_r.pin_prev[ch];
            fall     = !st_r.pin_s2[ch] && st_r.pin_prev[ch];
            hit_edge = ((els == ELS_RISE) && rise) || ((els == ELS_FALL) && fall)
                       || ((els == ELS_BOTH) && (rise || fall));
            ev       = 1'b0;

            // channel behaviour by function
            case (mode)
                TCC_PORT:
                begin
                    st_nxt.drive[ch]   = 1'b0;
                    st_nxt.level[ch]   = ~st_r.ctrl[ch][B_MSA];
                    st_nxt.max_eff[ch] = 1'b0;
                end
                TCC_CAPTURE:
                begin
                    st_nxt.drive[ch]   = 1'b0;
                    st_nxt.max_eff[ch] = 1'b0;
                    if (hit_edge && !st_r.cap_block[ch])
                    begin
                        st_nxt.val[ch] = counter_value;
                        ev             = 1'b1;
                    end
                end
                TCC_COMPARE:
                begin
                    st_nxt.drive[ch] = 1'b1;
                    ev               = match;
                    // full-duty request is sampled only at the cycle boundary
                    if (counter_overflow)
                    begin
                        st_nxt.max_eff[ch] = st_r.ctrl[ch][B_MAX] && st_r.ctrl[ch][B_TOV];
                    end
                    if (st_r.max_eff[ch])
                    begin
                        st_nxt.level[ch] = 1'b1;
                    end
                    else if (counter_overflow && st_r.ctrl[ch][B_TOV])
                    begin
                        st_nxt.level[ch] = ~st_r.level[ch];
                    end
                    else if (match)
                    begin
                        st_nxt.level[ch] = cmp_action(els, st_r.level[ch]);
                    end
                end
                default:
                begin
                    st_nxt.drive[ch] = 1'b0;
                end
            endcase

            // event flag and sticky status; an event beats a clear
            if (ev)
            begin
                st_nxt.ctrl[ch][B_FLAG] = 1'b1;
                st_nxt.clr_armed[ch]    = 1'b0;
            end
        end

        // interrupt status clears on read, mask is plain storage
        if (rd && addr_is(paddr, IDX_IRQ_STAT))
        begin
            st_nxt.irq_stat = '0;
        end
        if (wr && addr_is(paddr, IDX_IRQ_MASK))
        begin
            st_nxt.irq_mask = pwdata[CH_N-1:0];
        end
        for (int ch = 0; ch < CH_N; ch++)
        begin
            if (st_nxt.ctrl[ch][B_FLAG] && !st_r.ctrl[ch][B_FLAG])
            begin
                st_nxt.irq_stat[ch] = 1'b1;
            end
        end

        // read data is fetched in the setup cycle
        for (int ch = 0; ch < CH_N; ch++)
        begin
            if (addr_is(paddr, IDX_CTRL[ch]))
            begin
                rmux = {24'h000000, ((ch == 1) && buf_on) ? CTRL_RST : st_r.ctrl[ch]};
            end
            if (addr_is(paddr, IDX_VAL_HI[ch]))
            begin
                rmux = {24'h000000, st_r.val[ch][15:8]};
            end
            if (addr_is(paddr, IDX_VAL_LO[ch]))
            begin
                rmux = {24'h000000, st_r.val[ch][7:0]};
            end
        end
        if (addr_is(paddr, IDX_IRQ_STAT))
        begin
            rmux = {30'h00000000, st_r.irq_stat};
        end
        if (addr_is(paddr, IDX_IRQ_MASK))
        begin
            rmux = {30'h00000000, st_r.irq_mask};
        end
        if (psel && !penable && !pwrite)
        begin
            st_nxt.rdata = rmux;
        end

        pslverr = access && !mapped;
    end

    // state register; control bits and flags start cleared
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign pready          = 1'b1;
    assign prdata          = st_r.rdata;
    assign channel_pin_out = st_r.level;
    assign channel_pin_oe  = st_r.drive;
    assign irq             = |(st_r.irq_stat & st_r.irq_mask);

endmodule

// ---- hw/tcc_pkg.sv ----
// constants, modes and state record of the timer channel capture/compare block
package tcc_pkg;

    // channel count and value width
    localparam int CH_N  = 2;
    localparam int VAL_W = 16;

    // register indices; byte address is four times the index
    localparam logic [CH_N-1:0][7:0] IDX_CTRL   = {8'h28, 8'h25};
    localparam logic [CH_N-1:0][7:0] IDX_VAL_HI = {8'h29, 8'h26};
    localparam logic [CH_N-1:0][7:0] IDX_VAL_LO = {8'h2A, 8'h27};
    localparam logic [7:0]           IDX_IRQ_STAT = 8'h2C;
    localparam logic [7:0]           IDX_IRQ_MASK = 8'h2D;

    // channel control register field positions
    localparam int B_FLAG = 7;
    localparam int B_IE   = 6;
    localparam int B_BUF  = 5;
    localparam int B_MSA  = 4;
    localparam int B_ELSU = 3;
    localparam int B_ELSL = 2;
    localparam int B_TOV  = 1;
    localparam int B_MAX  = 0;

    // edge/level codes: capture edge or compare action
    localparam logic [1:0] ELS_OFF  = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;

    // values after reset
    localparam logic [7:0]       CTRL_RST = 8'h00;
    localparam logic [VAL_W-1:0] VAL_RST  = 16'h0000;

    // channel function
    typedef enum logic [1:0] {TCC_PORT, TCC_CAPTURE, TCC_COMPARE} tcc_mode_type;

    // whole state of the block, registered in one place
    typedef struct packed {
        logic [CH_N-1:0][7:0]       ctrl;
        logic [CH_N-1:0][VAL_W-1:0] val;
        logic [CH_N-1:0]            cap_block;
        logic [CH_N-1:0]            cmp_inhibit;
        logic [CH_N-1:0]            level;
        logic [CH_N-1:0]            drive;
        logic [CH_N-1:0]            clr_armed;
        logic [CH_N-1:0]            match_prev;
        logic [CH_N-1:0]            pin_s1;
        logic [CH_N-1:0]            pin_s2;
        logic [CH_N-1:0]            pin_prev;
        logic [CH_N-1:0]            max_eff;
        logic [CH_N-1:0]            irq_stat;
        logic [CH_N-1:0]            irq_mask;
        logic                       act_sel;
        logic [31:0]                rdata;
    } tcc_state_type;

    localparam tcc_state_type ST_RST = '0;

endpackage

// ---- test/tb.sv ----
// self-checking bench for the timer channel block
`timescale 1ns/1ps
module tb;
    import tcc_pkg::*;
    localparam logic [15:0] MD = 16'h00FF;
    logic        core_clk  = 0;
    logic        rst_b     = 0;
    logic        psel      = 0;
    logic        penable   = 0;
    logic        pwrite    = 0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] cnt       = 16'h0000;
    logic        ovf       = 0;
    logic        run       = 0;
    logic [1:0]  want      = 2'h2;
    logic [1:0]  pin_in;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic        irq;
    logic [15:0] rnd       = 16'h0033;
    logic [15:0] last;
    logic [15:0] v;
    logic [31:0] rv;
    logic        p;
    logic        b;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    tcc_channels tcc_channels_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_value(cnt), .counter_overflow(ovf), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));
    tcc_pin_src tcc_pin_src_i (.want(want), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .channel_pin_in(pin_in));
    always #50 core_clk = ~core_clk;
    // timer counter with overflow pulse, held while run is low; hang limit
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        ovf <= run && cnt == MD;
        if (run)
            cnt <= (cnt == MD) ? 16'h0000 : cnt + 16'h0001;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic cap_exp(input int c, input int e);
        return e == 0 ? c[0] : c[1];
    endfunction
    function automatic logic cmp_exp(input int c, input logic q);
        return c == 1 ? !q : c == 3;
    endfunction
    // one bus transfer; read data and error taken at the ready edge
    task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        psel   <= 1;
        pwrite <= w;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rv = prdata;
        p  = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // load the counter, let it run n cycles, then halt it
    task automatic go(input logic [15:0] s, input int n);
        @(posedge core_clk);
        cnt <= s;
        run <= 1;
        repeat (n) @(posedge core_clk);
        run <= 0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence: reset, capture, compare, overflow, full duty, buffered
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1;
        repeat (3) @(posedge core_clk);
        chk("pin_oe", 2'h0, pin_oe);
        chk("pin_out", 2'h3, pin_out);
        apb(IDX_CTRL[0], 0, 8'h00);
        chk("ctrl0", 16'h0000, rv[15:0]);
        apb(8'h2B, 0, 8'h00);
        chk("unmapped", 1'b1, p);
        apb(IDX_IRQ_MASK, 1, 8'h01);
        apb(IDX_CTRL[0], 1, 8'h10);
        repeat (3) @(posedge core_clk);
        chk("preset_low", 1'b0, pin_out[0]);
        for (int c = 1; c < 4; c++)
        begin
            apb(IDX_CTRL[0], 1, 8'(c) << 2);
            for (int e = 0; e < 2; e++)
            begin
                rnd = lf(rnd);
                cnt <= rnd;
                want[0] <= (e == 0);
                repeat (6) @(posedge core_clk);
                apb(IDX_CTRL[0], 0, 8'h00);
                chk("cap_flag", cap_exp(c, e), rv[7]);
                if (cap_exp(c, e))
                    last = rnd;
                apb(IDX_VAL_HI[0], 0, 8'h00);
                v[15:8] = rv[7:0];
                apb(IDX_VAL_LO[0], 0, 8'h00);
                v[7:0] = rv[7:0];
                chk("cap_val", last, v);
                apb(IDX_CTRL[0], 1, 8'(c) << 2);
            end
        end
        chk("irq_up", 1'b1, irq);
        apb(IDX_IRQ_STAT, 0, 8'h00);
        chk("irq_stat", 1'b1, rv[0]);
        @(posedge core_clk);
        chk("irq_clr", 1'b0, irq);
        apb(IDX_VAL_HI[0], 0, 8'h00);
        cnt <= lf(rnd);
        want[0] <= 1;
        repeat (6) @(posedge core_clk);
        apb(IDX_VAL_LO[0], 0, 8'h00);
        v[7:0] = rv[7:0];
        apb(IDX_VAL_HI[0], 0, 8'h00);
        v[15:8] = rv[7:0];
        chk("cap_block", last, v);
        apb(IDX_VAL_LO[0], 0, 8'h00);
        apb(IDX_IRQ_MASK, 1, 8'h00);
        for (int c = 1; c < 4; c++)
        begin
            rnd = lf(rnd);
            v = {8'h00, rnd[7:4], 4'h8};
            apb(IDX_CTRL[0], 1, 8'h10 | 8'(c) << 2);
            repeat (3) @(posedge core_clk);
            b = pin_out[0];
            apb(IDX_VAL_HI[0], 1, v[15:8]);
            go(v - 16'h0003, 6);
            chk("cmp_block", b, pin_out[0]);
            apb(IDX_VAL_LO[0], 1, v[7:0]);
            go(v - 16'h0003, 6);
            chk("cmp_out", cmp_exp(c, b), pin_out[0]);
        end
        apb(IDX_VAL_HI[0], 1, 8'h00);
        apb(IDX_VAL_LO[0], 1, 8'h00);
        apb(IDX_CTRL[0], 1, 8'h1A);
        for (int k = 0; k < 2; k++)
        begin
            b = pin_out[0];
            go(MD - 16'h0002, 5);
            chk("ovf_toggle", !b, pin_out[0]);
        end
        apb(IDX_VAL_LO[0], 1, 8'h80);
        apb(IDX_CTRL[0], 1, 8'h1B);
        go(MD - 16'h0002, 300);
        chk("full_duty", 1'b1, pin_out[0]);
        apb(IDX_CTRL[0], 1, 8'h1A);
        go(16'h0010, 120);
        chk("full_hold", 1'b1, pin_out[0]);
        go(MD - 16'h0002, 200);
        chk("full_off", 1'b0, pin_out[0]);
        chk("irq_masked", 1'b0, irq);
        apb(IDX_IRQ_MASK, 1, 8'h01);
        repeat (2) @(posedge core_clk);
        chk("irq_unmask", 1'b1, irq);
        apb(IDX_CTRL[0], 1, 8'h3A);
        apb(IDX_CTRL[1], 1, 8'h1B);
        apb(IDX_CTRL[1], 0, 8'h00);
        chk("ctrl1_off", 16'h0000, rv[15:0]);
        chk("ch1_oe", 1'b0, pin_oe[1]);
        summarize();
    end
endmodule
bind tcc_channels tcc_channels_chk tcc_channels_chk_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .counter_value(counter_value), .counter_overflow(counter_overflow),
    .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe), .irq(irq));

// ---- test/tcc_channels_chk.sv ----
// port assertions for the timer channel block
`timescale 1ns/1ps
module tcc_channels_chk
    import tcc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [15:0] counter_value,
    input wire logic        counter_overflow,
    input wire logic [1:0]  channel_pin_out,
    input wire logic [1:0]  channel_pin_oe,
    input wire logic        irq
);
    logic [7:0] c0;
    logic [1:0] mk;
    logic       mx;
    logic       wr;
    logic       cmp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // bus write strobe and compare mode of channel 0
    assign wr  = psel && penable && pwrite && pready;
    assign cmp = (c0[5] || c0[4]) && c0[3:2] != ELS_OFF;
    // shadow of control 0 and mask; mx marks any use of full duty
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            c0 <= 8'h00;
            mk <= 2'h0;
            mx <= 1'b0;
        end
        else
        begin
            if (wr && paddr == {2'b00, IDX_CTRL[0], 2'b00})
                c0 <= pwdata[7:0];
            if (wr && paddr == {2'b00, IDX_IRQ_MASK, 2'b00})
                mk <= pwdata[1:0];
            mx <= mx || c0[0];
        end
    end
    property p_port_off;
        (c0[3:2] == ELS_OFF) [*3] |-> !channel_pin_oe[0];
    endproperty
    a_port_off: assert property (p_port_off) else $error("channel 0 drives while off");
    property p_preset;
        (c0[3:2] == ELS_OFF && $stable(c0)) [*3] |-> channel_pin_out[0] == !c0[4];
    endproperty
    a_preset: assert property (p_preset) else $error("preset level wrong");
    property p_buf_ch1;
        c0[5] [*3] |-> !channel_pin_oe[1];
    endproperty
    a_buf_ch1: assert property (p_buf_ch1) else $error("channel 1 drives while buffered");
    property p_rst;
        $rose(rst_b) |-> (channel_pin_oe == 2'h0) [*2];
    endproperty
    a_rst: assert property (p_rst) else $error("pin enabled after reset");
    property p_quiet;
        (!psel && !counter_overflow && $stable(counter_value)) [*4] |=> $stable(channel_pin_out);
    endproperty
    a_quiet: assert property (p_quiet) else $error("output moved with no cause");
    property p_ovf;
        cmp && c0[1] && !c0[0] && !mx && counter_overflow && $stable(c0)
            |=> channel_pin_out[0] != $past(channel_pin_out[0]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("no toggle at overflow");
    property p_max;
        cmp && c0[1] && c0[0] && counter_overflow && $stable(c0) |-> ##2 channel_pin_out[0] [*4];
    endproperty
    a_max: assert property (p_max) else $error("full duty not held");
    property p_mask;
        (mk == 2'h0) [*2] |-> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt while masked");
endmodule

// ---- test/tcc_pin_src.sv ----
// external source and load on the two channel pins
`timescale 1ns/1ps
module tcc_pin_src
(
    input  wire logic [1:0] want,
    input  wire logic [1:0] channel_pin_out,
    input  wire logic [1:0] channel_pin_oe,
    output logic      [1:0] channel_pin_in
);
    // wire shows the channel drive while enabled, else the source level
    always_comb
        for (int i = 0; i < 2; i++)
            channel_pin_in[i] = channel_pin_oe[i] ? channel_pin_out[i] : want[i];
endmodule
